// file: rtl/flash_prot_pkg.sv
// Constants and types shared by the flash protection register logic
// Overview of operation
// RULE_01: Write-enable instruction sets the latch
// RULE_02: Latch clear refuses write-gated instructions
// RULE_03: Host sends write-enable before program or erase
// RULE_04: Host sends write-enable before register writes
// RULE_05: Parameter sets and row erase need latch
// RULE_06: Volatile parameter sets run without latch
// RULE_07: Write-disable instruction clears the latch
// RULE_08: Completed program, erase, write clears latch
// RULE_09: Program or erase into protected area refused
// RULE_10: Upper protection codes guard top blocks
// RULE_11: Lower codes guard bottom blocks; 0000/1111 none
// RULE_12: Chip erase only with protection code zero
// RULE_13: Disable bit and low pin block writes
// RULE_14: Otherwise status register writes are accepted
// RULE_15: Quad enable turns control pins into data
// RULE_16: Host keeps quad off with strapped pins
// RULE_17: Program suspend flag at function bit 2
// RULE_18: Erase suspend flag at function bit 3
// RULE_19: Row lock bits 4-7 refuse row programming
// RULE_20: One-time bits never return to zero
// RULE_21: Reset-disable bit moves reset to shared pin
// RULE_22: Function bit 1 reserved, read-only
// RULE_23: Only enable/disable instructions change the latch
// RULE_24: Busy flag set; other instructions ignored
// RULE_25: Status layout busy, latch, code, quad, disable
// RULE_26: Block index is address bits 20 to 16
package flash_prot_pkg;
	// Instruction codes
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OPC_QUAD_PROGRAM_A = 8'h32;
	localparam logic [7:0] OPC_QUAD_PROGRAM_B = 8'h38;
	localparam logic [7:0] OPC_SECTOR_ERASE_A = 8'hD7;
	localparam logic [7:0] OPC_SECTOR_ERASE_B = 8'h20;
	localparam logic [7:0] OPC_BLOCK_ERASE_SMALL = 8'h52;
	localparam logic [7:0] OPC_BLOCK_ERASE_LARGE = 8'hD8;
	localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hC7;
	localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OPC_FUNCTION_WRITE = 8'h42;
	localparam logic [7:0] OPC_NV_READ_PARAM = 8'h65;
	localparam logic [7:0] OPC_NV_EXT_READ_PARAM = 8'h85;
	localparam logic [7:0] OPC_INFO_ROW_ERASE = 8'h64;
	localparam logic [7:0] OPC_INFO_ROW_PROGRAM = 8'h62;
	localparam logic [7:0] OPC_AUTOBOOT_WRITE = 8'h15;
	localparam logic [7:0] OPC_VOL_READ_PARAM_A = 8'hC0;
	localparam logic [7:0] OPC_VOL_READ_PARAM_B = 8'h63;
	localparam logic [7:0] OPC_SUSPEND = 8'hB0;
	localparam logic [7:0] OPC_RESUME = 8'h30;
	// Status register bit positions
	localparam int SR_BUSY_BIT = 0;
	localparam int SR_WEL_BIT = 1;
	localparam int SR_CODE_LSB = 2;
	localparam int SR_QUAD_BIT = 6;
	localparam int SR_SWD_BIT = 7;
	// Function register bit positions
	localparam int FR_DRD_BIT = 0;
	localparam int FR_PROGRAM_SUSPENDED_FLAG_BIT = 2;
	localparam int FR_ERASE_SUSPENDED_FLAG_BIT = 3;
	localparam int FR_LOCK_LSB = 4;
	// Reset values
	localparam logic [3:0] CODE_RESET = 4'h0;
	localparam logic [3:0] LOCK_RESET = 4'h0;
	localparam logic DRD_RESET = 1'b0;
	// Operation durations in ref_clk cycles
	localparam logic [15:0] PROG_CYCLES = 16'h0040;
	localparam logic [15:0] ERASE_CYCLES = 16'h0100;
	localparam logic [15:0] REGWR_CYCLES = 16'h0020;
	typedef enum {ST_IDLE, ST_BUSY, ST_SUSPENDED} opState_t;
	typedef enum {OP_NONE, OP_PROGRAM, OP_ERASE, OP_REGWRITE} opKind_t;
endpackage : flash_prot_pkg

// file: rtl/link_cmd_if.sv
// Carrier for decoded instructions from the serial-clock side to the core
`timescale 1ns/1ps
interface link_cmd_if;
	logic toggle; // Flips once per captured instruction
	logic [7:0] opcode; // Held instruction code
	logic [23:0] addr; // Held target address
	logic [7:0] data; // Held first data byte
	modport link (output toggle, output opcode, output addr, output data);
	modport core (input toggle, input opcode, input addr, input data);
endinterface : link_cmd_if

// file: rtl/link_capture.sv
// Serial-clock side capture of decoded instructions
`timescale 1ns/1ps
module link_capture (
	input wire logic linkClk, // Serial clock from the host
	input wire logic rst_n, // System reset, not yet in this domain
	input wire logic cmdStrobe, // One-cycle strobe of a decoded instruction
	input wire logic [7:0] cmdOpcode, // Instruction code
	input wire logic [23:0] cmdAddr, // Target address
	input wire logic [7:0] cmdData, // First data byte
	link_cmd_if.link cmdPort // Towards the core domain
);
	logic rstMeta;
	logic rstSync;

	// Reset brought into the link domain; the clock may stop between frames
	always_ff @(posedge linkClk) begin
		rstMeta <= rst_n;
		rstSync <= rstMeta;
	end

	// Words are held until the next strobe so the core reads them stable
	always_ff @(posedge linkClk) begin
		if (!rstSync) begin
			cmdPort.toggle <= 1'b0;
			cmdPort.opcode <= 8'h00;
			cmdPort.addr <= 24'h000000;
			cmdPort.data <= 8'h00;
		end else if (cmdStrobe) begin
			cmdPort.toggle <= ~cmdPort.toggle;
			cmdPort.opcode <= cmdOpcode;
			cmdPort.addr <= cmdAddr;
			cmdPort.data <= cmdData;
		end
	end
endmodule : link_capture

// file: rtl/flash_write_protect_status_regs.sv
// Status and function register logic with write protection
`timescale 1ns/1ps
module flash_write_protect_status_regs
	import flash_prot_pkg::*;
#(
	parameter logic DRD_DEFAULT = DRD_RESET, // Reset-disable default per variant
	parameter logic [15:0] PROG_COUNT = PROG_CYCLES, // Program duration
	parameter logic [15:0] ERASE_COUNT = ERASE_CYCLES, // Erase duration
	parameter logic [15:0] REGWR_COUNT = REGWR_CYCLES // Register write duration
) (
	input wire logic ref_clk, // Core clock, 20 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic linkClk, // Serial clock from the host
	input wire logic cmdStrobe, // Decoded instruction strobe, linkClk domain
	input wire logic [7:0] cmdOpcode, // Instruction code
	input wire logic [23:0] cmdAddr, // Target address
	input wire logic [7:0] cmdData, // First data byte
	input wire logic writeProtect_n, // Write-protect pin
	input wire logic holdReset_n, // Shared hold/reset pin
	input wire logic dedReset_n, // Dedicated reset pin
	output logic [7:0] statusOut, // Status register image
	output logic [7:0] functionOut, // Function register image
	output logic quadMode, // Control pins act as data lines
	output logic resetReq, // Reset requested by the selected pin
	output logic opDone, // Pulse at end of an operation
	output logic cmdReject // Pulse when an instruction is refused
);
	link_cmd_if cmdBus ();
	opState_t state;
	opKind_t kind;
	logic [15:0] count;
	logic tglMeta, tglSync, tglSeen;
	logic wpMeta, wpSync, holdMeta, holdSync, dedMeta, dedSync;
	logic write_enable_latch, quad, swd, drd, program_suspended_flag, erase_suspended_flag;
	logic [3:0] code, lock;
	logic [7:0] pendOpcode, pendData;
	logic cmdEvent, idle, finishing, suspendHit, resumeHit;
	logic isWren, isWrdi, isProg, isErase, isChip, isRegWr, isVolSet;
	logic isInfoProg, isInfoErase, needsWel, blockProt, swLocked, rowLocked;
	logic startOp, refuse;
	logic [15:0] next_count;
	opKind_t next_kind;

	link_capture linkSide (
		.linkClk(linkClk),
		.rst_n(rst_n),
		.cmdStrobe(cmdStrobe),
		.cmdOpcode(cmdOpcode),
		.cmdAddr(cmdAddr),
		.cmdData(cmdData),
		.cmdPort(cmdBus.link)
	);

	// Decodes the protected range from the four-bit code
	function automatic logic inProtected(input logic [3:0] pc,
		input logic [4:0] blk);
		logic hit;
		hit = 1'b0;
		case (pc)
			4'h1: hit = (blk == 5'h1F); // RULE_10
			4'h2: hit = (blk >= 5'h1E); // RULE_10
			4'h3: hit = (blk >= 5'h1C); // RULE_10
			4'h4: hit = (blk >= 5'h18); // RULE_10
			4'h5: hit = (blk >= 5'h10); // RULE_10
			4'h6, 4'h7, 4'h8, 4'h9: hit = 1'b1; // RULE_10
			4'hA: hit = (blk <= 5'h0F); // RULE_11
			4'hB: hit = (blk <= 5'h07); // RULE_11
			4'hC: hit = (blk <= 5'h03); // RULE_11
			4'hD: hit = (blk <= 5'h01); // RULE_11
			4'hE: hit = (blk == 5'h00); // RULE_11
			default: hit = 1'b0; // RULE_11
		endcase
		return hit;
	endfunction : inProtected

	// Toggle and pins cross in through two flops each
	always_ff @(posedge ref_clk) begin
		tglMeta <= cmdBus.toggle;
		tglSync <= tglMeta;
		wpMeta <= writeProtect_n;
		wpSync <= wpMeta;
		holdMeta <= holdReset_n;
		holdSync <= holdMeta;
		dedMeta <= dedReset_n;
		dedSync <= dedMeta;
	end

	// Seen copy follows the synchroniser so no event fires out of reset
	always_ff @(posedge ref_clk) begin
		tglSeen <= tglSync;
	end

	assign cmdEvent = tglSync ^ tglSeen;
	assign idle = (state == ST_IDLE);
	assign suspendHit = cmdEvent && (state == ST_BUSY) &&
		(cmdBus.opcode == OPC_SUSPEND) && (kind != OP_REGWRITE);
	assign resumeHit = cmdEvent && (state == ST_SUSPENDED) &&
		(cmdBus.opcode == OPC_RESUME);
	assign finishing = (state == ST_BUSY) && (count == 16'h0001) &&
		!suspendHit;

	// Instruction classes
	always_comb begin
		isWren = (cmdBus.opcode == OPC_WRITE_ENABLE);
		isWrdi = (cmdBus.opcode == OPC_WRITE_DISABLE);
		isInfoProg = (cmdBus.opcode == OPC_INFO_ROW_PROGRAM);
		isInfoErase = (cmdBus.opcode == OPC_INFO_ROW_ERASE);
		isChip = (cmdBus.opcode == OPC_CHIP_ERASE_A) ||
			(cmdBus.opcode == OPC_CHIP_ERASE_B);
		isProg = (cmdBus.opcode == OPC_PAGE_PROGRAM) ||
			(cmdBus.opcode == OPC_QUAD_PROGRAM_A) ||
			(cmdBus.opcode == OPC_QUAD_PROGRAM_B);
		isErase = isChip || (cmdBus.opcode == OPC_SECTOR_ERASE_A) ||
			(cmdBus.opcode == OPC_SECTOR_ERASE_B) ||
			(cmdBus.opcode == OPC_BLOCK_ERASE_SMALL) ||
			(cmdBus.opcode == OPC_BLOCK_ERASE_LARGE);
		isRegWr = (cmdBus.opcode == OPC_STATUS_WRITE) ||
			(cmdBus.opcode == OPC_FUNCTION_WRITE) ||
			(cmdBus.opcode == OPC_NV_READ_PARAM) || // RULE_05
			(cmdBus.opcode == OPC_NV_EXT_READ_PARAM) || // RULE_05
			(cmdBus.opcode == OPC_AUTOBOOT_WRITE);
		isVolSet = (cmdBus.opcode == OPC_VOL_READ_PARAM_A) ||
			(cmdBus.opcode == OPC_VOL_READ_PARAM_B);
		needsWel = isProg || isErase || isRegWr || isInfoProg ||
			isInfoErase; // RULE_05
	end

	// Gating checks applied when an instruction arrives
	always_comb begin
		blockProt = (isProg || (isErase && !isChip)) &&
			inProtected(code, cmdBus.addr[20:16]); // RULE_09 RULE_26
		// Write-protect pin only counts while it is not a data line
		swLocked = (cmdBus.opcode == OPC_STATUS_WRITE) && swd &&
			!wpSync && !quad; // RULE_13 RULE_14 RULE_15
		rowLocked = isInfoProg && lock[cmdBus.addr[9:8]]; // RULE_19
		startOp = cmdEvent && idle && write_enable_latch && needsWel && !blockProt &&
			!(isChip && (code != 4'h0)) && // RULE_12
			!swLocked && !rowLocked; // RULE_02
		refuse = cmdEvent && needsWel && !startOp; // RULE_02 RULE_24
	end

	// Duration and class of the operation to start
	always_comb begin
		next_kind = OP_REGWRITE;
		next_count = REGWR_COUNT;
		if (isProg || isInfoProg) begin
			next_kind = OP_PROGRAM;
			next_count = PROG_COUNT;
		end else if (isErase || isInfoErase) begin
			next_kind = OP_ERASE;
			next_count = ERASE_COUNT;
		end
	end

	// Operation sequencer; suspend freezes the remaining count
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			kind <= OP_NONE;
			count <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (startOp) begin
						state <= ST_BUSY; // RULE_24
						kind <= next_kind;
						count <= next_count;
					end
				end
				ST_BUSY: begin
					if (suspendHit) begin
						state <= ST_SUSPENDED;
					end else if (finishing) begin
						state <= ST_IDLE;
						kind <= OP_NONE;
					end else begin
						count <= count - 16'h0001;
					end
				end
				ST_SUSPENDED: begin
					if (resumeHit) begin
						state <= ST_BUSY;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Captured instruction awaiting completion
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pendOpcode <= 8'h00;
			pendData <= 8'h00;
		end else if (startOp) begin
			pendOpcode <= cmdBus.opcode;
			pendData <= cmdBus.data;
		end
	end

	// Latch moves only by its own instructions and by completion
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			write_enable_latch <= 1'b0;
		end else if (finishing) begin
			write_enable_latch <= 1'b0; // RULE_08
		end else if (cmdEvent && (state != ST_BUSY) && isWren) begin
			write_enable_latch <= 1'b1; // RULE_01 RULE_23
		end else if (cmdEvent && (state != ST_BUSY) && isWrdi) begin
			write_enable_latch <= 1'b0; // RULE_07 RULE_23
		end
	end

	// Status bits commit at the end of the write, never the latch
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			code <= CODE_RESET;
			quad <= 1'b0;
			swd <= 1'b0;
		end else if (finishing && (pendOpcode == OPC_STATUS_WRITE)) begin
			code <= pendData[SR_CODE_LSB +: 4]; // RULE_14
			quad <= pendData[SR_QUAD_BIT];
			swd <= pendData[SR_SWD_BIT];
		end
	end

	// One-time bits can only be ORed in; clearing writes do nothing
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			drd <= DRD_DEFAULT;
			lock <= LOCK_RESET;
		end else if (finishing && (pendOpcode == OPC_FUNCTION_WRITE)) begin
			drd <= drd | pendData[FR_DRD_BIT]; // RULE_20 RULE_21
			lock <= lock | pendData[FR_LOCK_LSB +: 4]; // RULE_19 RULE_20
		end
	end

	// Suspend flags follow the sequencer
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			program_suspended_flag <= 1'b0;
			erase_suspended_flag <= 1'b0;
		end else if (suspendHit) begin
			program_suspended_flag <= (kind == OP_PROGRAM); // RULE_17
			erase_suspended_flag <= (kind == OP_ERASE); // RULE_18
		end else if (resumeHit) begin
			program_suspended_flag <= 1'b0; // RULE_17
			erase_suspended_flag <= 1'b0; // RULE_18
		end
	end

	// Register images; reserved bit 1 is tied low
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			statusOut <= 8'h00;
			functionOut <= 8'h00;
		end else begin
			statusOut <= {swd, quad, code, write_enable_latch,
				(state == ST_BUSY)}; // RULE_25 RULE_24
			functionOut <= {lock, erase_suspended_flag, program_suspended_flag, 1'b0, drd}; // RULE_22
		end
	end

	// Pin roles; the shared pin cannot reset while it carries data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			quadMode <= 1'b0;
			resetReq <= 1'b0;
		end else begin
			quadMode <= quad; // RULE_15
			resetReq <= drd ? (!quad && !holdSync) : !dedSync; // RULE_21
		end
	end

	// Event pulses; volatile sets never refuse
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			opDone <= 1'b0;
			cmdReject <= 1'b0;
		end else begin
			opDone <= finishing;
			cmdReject <= refuse && !isVolSet; // RULE_06
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Gating, latch and image guards; the reject pulse is one cycle late
	chk_wel_set: assert property ( // RULE_01
		cmdEvent && idle && isWren |=> write_enable_latch)
		else $error("Write enable did not set latch");
	chk_wel_gate: assert property ( // RULE_02
		cmdEvent && idle && !write_enable_latch && needsWel |=>
		state == ST_IDLE && cmdReject)
		else $error("Write-gated instruction ran without latch");
	chk_vol_free: assert property ( // RULE_06
		cmdEvent && isVolSet |=> !cmdReject)
		else $error("Volatile set was refused");
	chk_wel_clear: assert property ( // RULE_07
		cmdEvent && idle && isWrdi |=> !write_enable_latch)
		else $error("Write disable did not clear latch");
	chk_done_clear: assert property ( // RULE_08
		finishing |=> !write_enable_latch ##1 !statusOut[SR_WEL_BIT])
		else $error("Latch survived completion");
	chk_wel_hold: assert property ( // RULE_23
		!cmdEvent && !finishing |=> write_enable_latch == $past(write_enable_latch))
		else $error("Latch moved without its instructions");
	chk_block_guard: assert property ( // RULE_09
		cmdEvent && idle && blockProt |=> state == ST_IDLE)
		else $error("Protected block was accepted");
	chk_chip_guard: assert property ( // RULE_12
		cmdEvent && idle && isChip && code != 4'h0 |=>
		state == ST_IDLE)
		else $error("Chip erase ran with protection set");
	chk_swd_lock: assert property ( // RULE_13
		cmdEvent && idle && swLocked |=> state == ST_IDLE)
		else $error("Locked status write accepted");
	chk_row_lock: assert property ( // RULE_19
		cmdEvent && idle && rowLocked |=>
		state == ST_IDLE && cmdReject)
		else $error("Locked information row was programmed");
	chk_otp_keep: assert property ( // RULE_20
		$past(rst_n) |-> (($past(lock) & ~lock) == 4'h0) &&
		!($past(drd) && !drd))
		else $error("One-time bit returned to zero");
	chk_quad_pin: assert property ( // RULE_15
		quadMode == $past(quad))
		else $error("Pin role does not follow quad enable");
	chk_busy_image: assert property ( // RULE_25
		state == ST_BUSY |=> statusOut[SR_BUSY_BIT])
		else $error("Busy flag missing from status image");
	chk_program_suspended_flag_flag: assert property ( // RULE_17
		suspendHit && kind == OP_PROGRAM |=>
		program_suspended_flag ##1 functionOut[FR_PROGRAM_SUSPENDED_FLAG_BIT])
		else $error("Program suspend flag not shown");
	chk_erase_suspended_flag_set: assert property ( // RULE_18
		suspendHit && kind == OP_ERASE |=> erase_suspended_flag && !program_suspended_flag)
		else $error("Erase suspend flag not set");
	chk_erase_suspended_flag_flag: assert property ( // RULE_18
		resumeHit |=> !erase_suspended_flag && !program_suspended_flag && state == ST_BUSY)
		else $error("Resume did not clear suspend flags");

	// Main scenarios worth seeing at least once
	cov_program: cover property (startOp && isProg ##[1:300] opDone);
	cov_suspend: cover property (suspendHit ##[1:200] resumeHit);
	cov_reject: cover property (cmdEvent && blockProt ##1 cmdReject);
	cov_hw_lock: cover property (cmdEvent && swLocked ##1 cmdReject);
	cov_erase_susp: cover property (suspendHit && kind == OP_ERASE);
endmodule : flash_write_protect_status_regs

// file: verification/host_model.sv
// Host controller model issuing decoded instructions on the serial clock
`timescale 1ns/1ps
module host_model
	import flash_prot_pkg::*;
(
	input wire logic linkClk, // Serial clock
	output logic cmdStrobe, // Instruction strobe
	output logic [7:0] cmdOpcode, // Instruction code
	output logic [23:0] cmdAddr, // Target address
	output logic [7:0] cmdData // First data byte
);
	// Idle lines start quiet
	initial begin
		cmdStrobe = 1'b0;
		cmdOpcode = 8'h00;
		cmdAddr = 24'h000000;
		cmdData = 8'h00;
	end
	// One strobe per word; released lines show the inverse so stale words
	// cannot pass for valid ones, then a gap keeps strobes 456 ns apart
	task automatic send(input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] d);
		@(posedge linkClk);
		#1;
		cmdStrobe = 1'b1;
		cmdOpcode = op;
		cmdAddr = a;
		cmdData = d;
		@(posedge linkClk);
		#1;
		cmdStrobe = 1'b0;
		cmdOpcode = ~op;
		cmdAddr = ~a;
		cmdData = ~d;
		repeat (36) @(posedge linkClk);
	endtask : send
	// Every write-gated instruction is preceded by a write enable
	task automatic gated(input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] d);
		send(OPC_WRITE_ENABLE, 24'h000000, 8'h00);
		send(op, a, d);
	endtask : gated
endmodule : host_model

// file: verification/tb_top.sv
// Self-checking bench for the flash protection register logic
`timescale 1ns/1ps
module tb_top
	import flash_prot_pkg::*;
;
	localparam logic [7:0] GATED [16] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20,
		8'h52, 8'hD8, 8'hC7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62,
		8'h15};
	localparam int BLKS [16] = '{0, 1, 2, 3, 4, 7, 8, 15, 16, 23, 24, 27, 28,
		29, 30, 31};
	logic ref_clk = 1'b0;
	logic linkClk = 1'b0;
	logic rst_n = 1'b0;
	logic writeProtect_n = 1'b1;
	logic holdReset_n = 1'b1;
	logic dedReset_n = 1'b1;
	logic cmdStrobe;
	logic [7:0] cmdOpcode;
	logic [23:0] cmdAddr;
	logic [7:0] cmdData;
	logic [7:0] statusOut;
	logic [7:0] functionOut;
	logic quadMode;
	logic resetReq;
	logic opDone;
	logic cmdReject;
	int miscompares = 0;
	int checkCount = 0;
	int rejects = 0;
	int dones = 0;
	// Core clock, and a link clock of unrelated phase
	always #25 ref_clk = ~ref_clk;
	initial begin
		#3.3;
		forever #6 linkClk = ~linkClk;
	end
	host_model host (.linkClk(linkClk), .cmdStrobe(cmdStrobe),
		.cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .cmdData(cmdData));
	// Short durations keep the protection sweep affordable
	flash_write_protect_status_regs #(.DRD_DEFAULT(1'b0),
		.PROG_COUNT(16'h003C), .ERASE_COUNT(16'h003C),
		.REGWR_COUNT(16'h0008)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.linkClk(linkClk), .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode),
		.cmdAddr(cmdAddr), .cmdData(cmdData),
		.writeProtect_n(writeProtect_n), .holdReset_n(holdReset_n),
		.dedReset_n(dedReset_n), .statusOut(statusOut),
		.functionOut(functionOut), .quadMode(quadMode), .resetReq(resetReq),
		.opDone(opDone), .cmdReject(cmdReject));
	// One-cycle pulses are tallied so no scenario can miss one
	always @(posedge ref_clk) begin
		if (opDone === 1'b1) dones++;
		if (cmdReject === 1'b1) rejects++;
	end
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Bounded wait until the busy flag drops
	task automatic waitIdle();
		int n;
		n = 0;
		repeat (4) @(posedge ref_clk);
		while (statusOut[0] !== 1'b0) begin
			@(posedge ref_clk);
			n++;
			if (n > 500) begin
				$display("FAIL t=%0t got=%h exp=%h", $time, statusOut, 8'h00);
				miscompares++;
				close_out();
			end
		end
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : waitIdle
	task automatic run(input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] d, input bit wen);
		if (wen)
			host.gated(op, a, d);
		else
			host.send(op, a, d);
		waitIdle();
	endtask : run
	// Refused work pulses the reject, accepted work ends with a done pulse
	task automatic expectOp(input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] d, input bit wen, input bit refused);
		int r0;
		int d0;
		r0 = rejects;
		d0 = dones;
		run(op, a, d, wen);
		check(rejects - r0, {31'h0, refused});
		check(dones - d0, {31'h0, !refused});
	endtask : expectOp
	task automatic pins(input logic wp, input logic hr, input logic dr);
		@(posedge ref_clk);
		#1;
		writeProtect_n = wp;
		holdReset_n = hr;
		dedReset_n = dr;
		repeat (5) @(posedge ref_clk);
		#1;
	endtask : pins
	function automatic logic isProt(input logic [3:0] c, input int b);
		case (c)
			4'h1: return b == 31;
			4'h2: return b >= 30;
			4'h3: return b >= 28;
			4'h4: return b >= 24;
			4'h5: return b >= 16;
			4'h6, 4'h7, 4'h8, 4'h9: return 1'b1;
			4'hA: return b <= 15;
			4'hB: return b <= 7;
			4'hC: return b <= 3;
			4'hD: return b <= 1;
			4'hE: return b == 0;
			default: return 1'b0;
		endcase
	endfunction : isProt
	task automatic tWel();
		run(OPC_WRITE_ENABLE, 24'h000000, 8'h00, 1'b0);
		check(statusOut, 8'h02);
		run(OPC_WRITE_DISABLE, 24'h000000, 8'h00, 1'b0);
		check(statusOut, 8'h00);
		run(OPC_STATUS_WRITE, 24'h000000, 8'h02, 1'b1);
		check(statusOut, 8'h00);
	endtask : tWel
	task automatic tGated();
		int r0;
		foreach (GATED[i]) begin
			expectOp(GATED[i], 24'h000000, 8'h00, 1'b0, 1'b1);
			check(statusOut, 8'h00);
		end
		r0 = rejects;
		run(OPC_VOL_READ_PARAM_A, 24'h000000, 8'h00, 1'b0);
		run(OPC_VOL_READ_PARAM_B, 24'h000000, 8'h00, 1'b0);
		check(rejects - r0, 32'h0);
	endtask : tGated
	// A write disable sent mid-operation is ignored; suspend flags follow
	task automatic tSuspend(input logic [7:0] op, input int flagBit);
		int d0;
		d0 = dones;
		host.gated(op, 24'h000000, 8'h00);
		host.send(OPC_WRITE_DISABLE, 24'h000000, 8'h00);
		check(statusOut[1:0], 2'b11);
		host.send(OPC_SUSPEND, 24'h000000, 8'h00);
		check(functionOut[flagBit], 1'b1);
		host.send(OPC_RESUME, 24'h000000, 8'h00);
		check(functionOut[3:2], 2'b00);
		waitIdle();
		check(dones - d0, 32'h1);
		check(statusOut[1:0], 2'b00);
	endtask : tSuspend
	task automatic tProtect();
		for (int c = 0; c < 16; c++) begin
			run(OPC_STATUS_WRITE, 24'h000000, {2'b00, 4'(c), 2'b00}, 1'b1);
			check(statusOut, {2'b00, 4'(c), 2'b00});
			foreach (BLKS[i])
				expectOp(OPC_PAGE_PROGRAM, {3'b000, 5'(BLKS[i]), 16'h0000}, 8'h00,
					1'b1, isProt(4'(c), BLKS[i]));
			expectOp(OPC_CHIP_ERASE_A, 24'h000000, 8'h00, 1'b1, c != 0);
		end
		expectOp(OPC_STATUS_WRITE, 24'h000000, 8'h00, 1'b1, 1'b0);
		expectOp(OPC_CHIP_ERASE_B, 24'h000000, 8'h00, 1'b1, 1'b0);
	endtask : tProtect
	task automatic tHwProtect();
		run(OPC_STATUS_WRITE, 24'h000000, 8'h80, 1'b1);
		pins(1'b0, 1'b1, 1'b1);
		expectOp(OPC_STATUS_WRITE, 24'h000000, 8'h84, 1'b1, 1'b1);
		check(statusOut[7:2], 6'h20);
		pins(1'b1, 1'b1, 1'b1);
		expectOp(OPC_STATUS_WRITE, 24'h000000, 8'h00, 1'b1, 1'b0);
		check(statusOut, 8'h00);
		// Pins stay driven, never strapped, while quad mode is on
		run(OPC_STATUS_WRITE, 24'h000000, 8'h40, 1'b1);
		check(quadMode, 1'b1);
		run(OPC_STATUS_WRITE, 24'h000000, 8'h00, 1'b1);
		check(quadMode, 1'b0);
	endtask : tHwProtect
	task automatic tFunction();
		run(OPC_FUNCTION_WRITE, 24'h000000, 8'h3E, 1'b1);
		check(functionOut, 8'h30);
		run(OPC_FUNCTION_WRITE, 24'h000000, 8'h00, 1'b1);
		check(functionOut, 8'h30);
		expectOp(OPC_INFO_ROW_PROGRAM, 24'h000000, 8'h00, 1'b1, 1'b1);
		expectOp(OPC_INFO_ROW_PROGRAM, 24'h000200, 8'h00, 1'b1, 1'b0);
	endtask : tFunction
	// Reset source moves from the dedicated pin to the shared pin
	task automatic tResetPin();
		pins(1'b1, 1'b0, 1'b1);
		check(resetReq, 1'b0);
		pins(1'b1, 1'b1, 1'b0);
		check(resetReq, 1'b1);
		pins(1'b1, 1'b1, 1'b1);
		run(OPC_FUNCTION_WRITE, 24'h000000, 8'h01, 1'b1);
		check(functionOut[0], 1'b1);
		pins(1'b1, 1'b1, 1'b0);
		check(resetReq, 1'b0);
		pins(1'b1, 1'b0, 1'b1);
		check(resetReq, 1'b1);
	endtask : tResetPin
	// Hang guard
	initial begin
		#4000000;
		$display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		miscompares++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		check(statusOut, 8'h00);
		check(functionOut, 8'h00);
		tWel();
		tGated();
		tSuspend(OPC_PAGE_PROGRAM, FR_PROGRAM_SUSPENDED_FLAG_BIT);
		tSuspend(OPC_BLOCK_ERASE_LARGE, FR_ERASE_SUSPENDED_FLAG_BIT);
		tProtect();
		tHwProtect();
		tFunction();
		tResetPin();
		close_out();
	end
endmodule : tb_top
